// ==== logic/epod_step_gen.sv ====
// Purpose: paced quadrature step generator from a signed step backlog
// Assumes: backlog produced by the divider on the same clock
// Notes: one quarter step per pacing interval at most
`timescale 1ns/100ps
module epod_step_gen
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic add_fwd,
    input wire logic add_rev,
    output logic [1:0] phase,
    output logic step_fwd,
    output logic step_rev
);
    logic [7:0] pace;
    logic signed [15:0] backlog;
    logic go;

    assign go = (pace == 8'h00) && (backlog != 16'sh0000);

    // pacing counter keeps edges at or under the rate ceiling
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            pace <= 8'h00;
        else if (go)
            pace <= 8'(epod_pkg::epod_quarter_cycles - 1);
        else if (pace != 8'h00)
            pace <= pace - 8'h01;
    end

    // backlog of quarter steps still owed to the host
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            backlog <= 16'sh0000;
        else
            backlog <= backlog + (add_fwd ? 16'sh0001 : 16'sh0000) - (add_rev ? 16'sh0001 : 16'sh0000)
                - ((go && backlog > 16'sh0000) ? 16'sh0001 : 16'sh0000)
                + ((go && backlog < 16'sh0000) ? 16'sh0001 : 16'sh0000);
    end

    // binary sequence 00,01,10,11 forward; reverse walks it backwards
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            phase <= 2'h0;
            step_fwd <= 1'b0;
            step_rev <= 1'b0;
        end
        else
        begin
            step_fwd <= go && backlog > 16'sh0000;
            step_rev <= go && backlog < 16'sh0000;
            if (go && backlog > 16'sh0000)
                phase <= phase + 2'h1;
            else if (go)
                phase <= phase - 2'h1;
        end
    end
endmodule

// ==== logic/epod_top.sv ====
// Purpose: divide encoder counts to configured output pulses per revolution
// Assumes: enc_step pulses are one native count each, from logic on mclk
// Notes: setting and resolution are latched on the first edge after reset
`timescale 1ns/100ps
module epod_top
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic [1:0] enc_resolution,
    input wire logic [30:0] output_pulses_per_rev,
    input wire logic rotation_direction_select,
    input wire logic [13:0] motor_speed_rpm,
    output epod_pkg::epod_out_s pins,
    output epod_pkg::epod_alarm_s alarms
);
    logic [30:0] ppr;
    logic [1:0] res;
    logic loaded;
    logic [20:0] native;
    logic [20:0] enc_pos;
    logic [33:0] acc;
    logic fwd_raw;
    logic add_fwd;
    logic add_rev;
    logic [1:0] phase;
    logic step_fwd;
    logic step_rev;
    logic [32:0] out_pos;
    logic [32:0] out_top;
    logic [30:0] lim;
    logic [13:0] rpm_lim;
    logic bad_step;
    logic bad_set;

    // capture setting once after restart; later changes are ignored
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ppr <= epod_pkg::epod_ppr_default;
            res <= epod_pkg::epod_res_13bit;
            loaded <= 1'b0;
        end
        else if (!loaded)
        begin
            ppr <= output_pulses_per_rev;
            res <= enc_resolution;
            loaded <= 1'b1;
        end
    end

    // native counts and maximum setting for the encoder fitted
    always_comb
    begin
        if (res == epod_pkg::epod_res_20bit)
        begin
            native = epod_pkg::epod_native_20bit;
            lim = epod_pkg::epod_lim_20bit;
        end
        else if (res == epod_pkg::epod_res_17bit)
        begin
            native = epod_pkg::epod_native_17bit;
            lim = epod_pkg::epod_lim_17bit;
        end
        else
        begin
            native = epod_pkg::epod_native_13bit;
            lim = epod_pkg::epod_lim_13bit;
        end
    end

    // band step check and band speed limit
    always_comb
    begin
        if (ppr <= epod_pkg::epod_band1_top)
        begin
            bad_step = 1'b0;
            rpm_lim = epod_pkg::epod_rpm_band1;
        end
        else if (ppr <= epod_pkg::epod_band2_top)
        begin
            bad_step = ppr[0];
            rpm_lim = epod_pkg::epod_rpm_band2;
        end
        else if (ppr <= epod_pkg::epod_band3_top)
        begin
            bad_step = |ppr[1:0];
            rpm_lim = epod_pkg::epod_rpm_band3;
        end
        else if (ppr <= epod_pkg::epod_band4_top)
        begin
            bad_step = |ppr[2:0];
            rpm_lim = epod_pkg::epod_rpm_band4;
        end
        else
        begin
            bad_step = |ppr[3:0];
            rpm_lim = epod_pkg::epod_rpm_band5;
        end
    end

    assign bad_set = (ppr < epod_pkg::epod_ppr_min) || (ppr > epod_pkg::epod_ppr_max)
        || (ppr > lim) || bad_step || (res == 2'h3);

    // alarms, registered
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            alarms <= '0;
        else
        begin
            alarms.setting <= loaded && bad_set;
            alarms.overspeed <= loaded && !bad_set && (motor_speed_rpm > rpm_lim);
        end
    end

    // direction of travel follows enc_dir alone; rotation_direction_select is not used and flips nothing
    assign fwd_raw = enc_dir;

    // encoder position within one revolution
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            enc_pos <= '0;
        else if (enc_step && fwd_raw)
            enc_pos <= (enc_pos == native - 21'h000001) ? 21'h000000 : enc_pos + 21'h000001;
        else if (enc_step)
            enc_pos <= (enc_pos == 21'h000000) ? native - 21'h000001 : enc_pos - 21'h000001;
    end

    // remainder accumulator: add 4*ppr per native count, emit a quarter step per native overflow
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            acc <= '0;
            add_fwd <= 1'b0;
            add_rev <= 1'b0;
        end
        else
        begin
            add_fwd <= 1'b0;
            add_rev <= 1'b0;
            if (loaded && !bad_set && enc_step && fwd_raw)
            begin
                if (acc + {1'b0, ppr, 2'h0} >= {13'h0000, native})
                begin
                    acc <= acc + {1'b0, ppr, 2'h0} - {13'h0000, native};
                    add_fwd <= 1'b1;
                end
                else
                    acc <= acc + {1'b0, ppr, 2'h0};
            end
            else if (loaded && !bad_set && enc_step)
            begin
                if (acc < {1'b0, ppr, 2'h0})
                begin
                    acc <= acc + {13'h0000, native} - {1'b0, ppr, 2'h0};
                    add_rev <= 1'b1;
                end
                else
                    acc <= acc - {1'b0, ppr, 2'h0};
            end
        end
    end

    epod_step_gen u_step
    (
        .mclk(mclk),
        .nrst(nrst),
        .add_fwd(add_fwd),
        .add_rev(add_rev),
        .phase(phase),
        .step_fwd(step_fwd),
        .step_rev(step_rev)
    );

    assign out_top = {ppr, 2'h0} - 33'h000000001;

    // output quarter-step position within the revolution
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            out_pos <= '0;
        else if (step_fwd)
            out_pos <= (out_pos == out_top) ? 33'h000000000 : out_pos + 33'h000000001;
        else if (step_rev)
            out_pos <= (out_pos == 33'h000000000) ? out_top : out_pos - 33'h000000001;
    end

    // drive complementary pins; index high over the first half pulse of the turn
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            pins <= 6'h15;
        else
        begin
            pins.a <= phase[1] ^ phase[0];
            pins.a_n <= ~(phase[1] ^ phase[0]);
            pins.b <= phase[1];
            pins.b_n <= ~phase[1];
            pins.c <= out_pos < 33'h000000002;
            pins.c_n <= ~(out_pos < 33'h000000002);
        end
    end
endmodule

// ==== shared/epod_pkg.sv ====
// Purpose: constants and carriers for the encoder pulse output divider
// Assumes: 100 MHz mclk, encoder position arrives as native counts per revolution
// Notes: none
package epod_pkg;
    localparam int unsigned epod_clk_hz = 100000000;
    localparam logic [30:0] epod_ppr_min = 31'h00000010;
    localparam logic [30:0] epod_ppr_max = 31'h40000000;
    localparam logic [30:0] epod_ppr_default = 31'h00000800;
    localparam logic [30:0] epod_lim_13bit = 31'h00000800;
    localparam logic [30:0] epod_lim_17bit = 31'h00008000;
    localparam logic [30:0] epod_lim_20bit = 31'h00040000;
    localparam logic [30:0] epod_band1_top = 31'h00004000;
    localparam logic [30:0] epod_band2_top = 31'h00008000;
    localparam logic [30:0] epod_band3_top = 31'h00010000;
    localparam logic [30:0] epod_band4_top = 31'h00020000;
    localparam logic [13:0] epod_rpm_band1 = 14'h1770;
    localparam logic [13:0] epod_rpm_band2 = 14'h0BB8;
    localparam logic [13:0] epod_rpm_band3 = 14'h05DC;
    localparam logic [13:0] epod_rpm_band4 = 14'h02EE;
    localparam logic [13:0] epod_rpm_band5 = 14'h0177;
    localparam int unsigned epod_max_pps = 1600000;
    // least quarter-step spacing at the 1.6 Mpps ceiling: four edges per pulse
    localparam int unsigned epod_quarter_cycles = (epod_clk_hz + 4 * epod_max_pps - 1) / (4 * epod_max_pps);
    localparam logic [1:0] epod_res_13bit = 2'h0;
    localparam logic [1:0] epod_res_17bit = 2'h1;
    localparam logic [1:0] epod_res_20bit = 2'h2;
    localparam logic [20:0] epod_native_13bit = 21'h002000;
    localparam logic [20:0] epod_native_17bit = 21'h020000;
    localparam logic [20:0] epod_native_20bit = 21'h100000;

    typedef struct packed {
        logic a;
        logic a_n;
        logic b;
        logic b_n;
        logic c;
        logic c_n;
    } epod_out_s;

    typedef struct packed {
        logic setting;
        logic overspeed;
    } epod_alarm_s;
endpackage

// ==== tb/epod_assertions.sv ====
// Purpose: port checker for the divider
// Assumes: one clock, sync active-low reset
// Notes: bound to epod_top below
`timescale 1ns/100ps
module epod_chk
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [13:0] motor_speed_rpm,
    input epod_pkg::epod_out_s pins,
    input epod_pkg::epod_alarm_s alarms
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // quarter step seen on the pair
    sequence quad_move_s;
        $changed({pins.a, pins.b});
    endsequence
    // speed held at or below the lowest band limit
    sequence slow_s;
        (motor_speed_rpm <= epod_pkg::epod_rpm_band5)[*3];
    endsequence
    pair_compl_a: assert property ({pins.a_n, pins.b_n, pins.c_n} == ~{pins.a, pins.b, pins.c})
        else $error("pin pair not complementary");
    gray_step_a: assert property (!($changed(pins.a) && $changed(pins.b)))
        else $error("a and b moved together");
    step_pace_a: assert property (quad_move_s |=> $stable({pins.a, pins.b})[*8])
        else $error("quarter steps too close");
    alarm_freeze_a: assert property (alarms.setting && $past(alarms.setting) |-> $stable({pins.a, pins.b}))
        else $error("output moved under setting alarm");
    slow_clear_a: assert property (slow_s |-> !alarms.overspeed)
        else $error("overspeed at low speed");
    fast_trip_a: assert property ((motor_speed_rpm > epod_pkg::epod_rpm_band1)[*4]
        |-> alarms.overspeed || alarms.setting)
        else $error("no overspeed above top limit");
    // the index standing at position zero rises once after reset with no quarter step behind it
    index_sync_a: assert property ($changed(pins.c) && $past(nrst, 2)
        |-> $past({pins.a, pins.b}) != $past({pins.a, pins.b}, 2))
        else $error("index moved off a quarter step");
    index_hold_a: assert property ($rose(pins.c) |=> pins.c[*8])
        else $error("index pulse too short");
endmodule
bind epod_top epod_chk u_chk (.mclk(mclk), .nrst(nrst), .motor_speed_rpm(motor_speed_rpm),
    .pins(pins), .alarms(alarms));

// ==== tb/epod_host_model.sv ====
// Purpose: host counter of quadrature feedback
// Assumes: pins sampled on mclk
// Notes: widths in cycles, last complete pulse
`timescale 1ns/100ps
module epod_host_model
(
    input wire logic mclk,
    input wire logic nrst,
    input epod_pkg::epod_out_s pins,
    output int pos,
    output int idx_cnt,
    output int idx_w,
    output int a_w,
    output int bad
);
    logic [1:0] g_q;
    int c_run;
    int a_run;
    wire logic [1:0] g = {pins.b, pins.a ^ pins.b};
    // decode quarters, a leading b counts up; measure pulse widths
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pos <= 0;
            idx_cnt <= 0;
            bad <= 0;
            g_q <= 2'h0;
            c_run <= 0;
            a_run <= 0;
        end
        else
        begin
            g_q <= g;
            if (g - g_q == 2'h1) pos <= pos + 1;
            else if (g - g_q == 2'h3) pos <= pos - 1;
            else if (g - g_q == 2'h2) bad <= bad + 1;
            c_run <= pins.c ? c_run + 1 : 0;
            a_run <= pins.a ? a_run + 1 : 0;
            if (!pins.c && c_run != 0) idx_w <= c_run;
            if (!pins.a && a_run != 0) a_w <= a_run;
            if (pins.c && c_run == 0) idx_cnt <= idx_cnt + 1;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the divider
// Assumes: 100 MHz mclk, inputs moved 1 ns after the edge
// Notes: 13 bit encoder at 16 pulses keeps a turn short
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic enc_step = 1'b0;
    logic enc_dir = 1'b1;
    logic [1:0] res = 2'h0;
    logic [30:0] ppr = 31'h00000010;
    logic rot_sel = 1'b0;
    logic [13:0] speed = 14'h0000;
    epod_pkg::epod_out_s pins;
    epod_pkg::epod_alarm_s alarms;
    int pos, idx_cnt, idx_w, a_w, bad;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [1:0] t_res [10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
    logic [30:0] t_ppr [10] = '{31'h00000800, 31'h00000801, 31'h0000000F, 31'h00008000, 31'h00004001,
        31'h000061A8, 31'h000061A9, 31'h00040000, 31'h00020018, 31'h00000800};
    logic t_bad [10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [30:0] b_ppr [5] = '{31'h00004000, 31'h00008000, 31'h00010000, 31'h00020000, 31'h00040000};
    logic [13:0] b_lim [5] = '{14'h1770, 14'h0BB8, 14'h05DC, 14'h02EE, 14'h0177};
    // clock
    always #5 mclk = ~mclk;
    epod_top u_dut (.mclk(mclk), .nrst(nrst), .enc_step(enc_step), .enc_dir(enc_dir), .enc_resolution(res),
        .output_pulses_per_rev(ppr), .rotation_direction_select(rot_sel), .motor_speed_rpm(speed),
        .pins(pins), .alarms(alarms));
    epod_host_model u_host (.mclk(mclk), .nrst(nrst), .pins(pins), .pos(pos), .idx_cnt(idx_cnt),
        .idx_w(idx_w), .a_w(a_w), .bad(bad));
    // compare and count
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // restart with a new resolution and setting
    task automatic do_reset(logic [1:0] r, logic [30:0] p);
        nrst = 1'b0;
        res = r;
        ppr = p;
        tick(20);
        nrst = 1'b1;
        tick(4);
    endtask
    // one encoder count per cycle, then let the pacing drain
    task automatic run(logic dir, int n);
        enc_dir = dir;
        enc_step = 1'b1;
        tick(n);
        enc_step = 1'b0;
        tick(300);
    endtask
    // one turn plus two quarters, so the index at the turn closes; the index standing at rest is not counted
    task automatic t_direction();
        int i0;
        do_reset(2'h0, 31'h00000010);
        speed = 14'h0000; // overspeed alarm kept clear; the index does not depend on speed
        i0 = idx_cnt;
        run(1'b1, 8448);
        check("pos fwd", 66, pos);
        check("index count", 1, idx_cnt - i0);
        check("phase a width", 256, a_w);
        check("index width", a_w, idx_w);
        check("bad steps", 0, bad);
        run(1'b0, 8448);
        check("pos rev", 0, pos);
    endtask
    task automatic t_select();
        rot_sel = 1'b1;
        do_reset(2'h0, 31'h00000010);
        run(1'b1, 8192);
        check("pos with reverse select", 64, pos);
        rot_sel = 1'b0;
    endtask
    task automatic t_setting();
        for (int i = 0; i < 10; i++)
        begin
            do_reset(t_res[i], t_ppr[i]);
            check("setting alarm", t_bad[i], alarms.setting);
            run(1'b1, 256);
            if (t_bad[i]) check("pos under alarm", 0, pos);
        end
    endtask
    task automatic t_speed();
        for (int i = 0; i < 5; i++)
        begin
            do_reset(2'h2, b_ppr[i]);
            speed = b_lim[i];
            tick(6);
            check("overspeed at limit", 0, alarms.overspeed);
            speed = b_lim[i] + 14'h0001;
            tick(6);
            check("overspeed above limit", 1, alarms.overspeed);
            speed = 14'h0000;
        end
    endtask
    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    // main sequence
    initial
    begin
        t_direction();
        t_select();
        t_setting();
        t_speed();
        stop_test();
    end
endmodule
